//--- hdl/dfc_regs.svh
// Register selects, reset values and cycle counts of the flow control block
`ifndef DFC_REGS_SVH
`define DFC_REGS_SVH

// -----------------------------------------------------------------------------
// Main bus register selects
// -----------------------------------------------------------------------------
`define DFC_SEL_LOOP_START   3'h0
`define DFC_SEL_LOOP_END     3'h1
`define DFC_SEL_LOOP_COUNT   3'h2
`define DFC_SEL_STK_START    3'h3
`define DFC_SEL_STK_END      3'h4
`define DFC_SEL_STK_COUNT    3'h5
`define DFC_SEL_LOOP_PTR     3'h6

// -----------------------------------------------------------------------------
// Field positions inside one loop save entry
// -----------------------------------------------------------------------------
`define DFC_LANE_START       2
`define DFC_LANE_END         1
`define DFC_LANE_COUNT       0

// -----------------------------------------------------------------------------
// Reset values and loop pointer limit
// -----------------------------------------------------------------------------
`define DFC_RST_LOOP_PTR     3'h0
`define DFC_RST_WORD         16'h0000
`define DFC_LOOP_PTR_MAX     3'h4

// -----------------------------------------------------------------------------
// Instruction cycle counts of taken branches and the single-iterate repeat gap
// -----------------------------------------------------------------------------
`define DFC_CYC_IMM          2'h2
`define DFC_CYC_IND          2'h3
`define DFC_CYC_COND_EXTRA   2'h1
`define DFC_CYC_REP_GAP      2'h1

`endif

//--- hdl/dfc_pkg.sv
// Types shared by the flow control block
package dfc_pkg;

    typedef enum logic [3:0] {
        DFC_OP_BRANCH_IMM,
        DFC_OP_BRANCH_IND,
        DFC_OP_CALL_IMM,
        DFC_OP_CALL_IND,
        DFC_OP_SUB_EXIT,
        DFC_OP_INT_EXIT,
        DFC_OP_INT_ACK,
        DFC_OP_LOOP_ENTER,
        DFC_OP_LOOP_DISCARD,
        DFC_OP_SINGLE_ITERATE
    } dfc_op_e;

    typedef logic [2:0] dfc_sel_t;

endpackage : dfc_pkg

//--- hdl/dfc_stack_mem.sv
// Lane-writable stack memory with registered, write-forwarded read data
`timescale 1ns/1ps
module dfc_stack_mem #(
    parameter int LANES  = 1,
    parameter int LANE_W = 16,
    parameter int ADDR_W = 4
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic [LANES-1:0]          wr_en,
    input  wire logic [ADDR_W-1:0]         wr_addr,
    input  wire logic [LANES*LANE_W-1:0]   wr_data,
    input  wire logic [ADDR_W-1:0]         rd_addr,
    output logic      [LANES*LANE_W-1:0]   rd_data
);

    // -------------------------------------------------------------------------
    // One storage column per lane
    // -------------------------------------------------------------------------
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] mem [2**ADDR_W];
        logic [LANE_W-1:0] rd_q;
        logic [LANE_W-1:0] rd_d;

        // Forward a same-cycle write so the pointer's entry is always current
        always_comb begin
            if (wr_en[g] && (wr_addr == rd_addr)) begin
                rd_d = wr_data[g*LANE_W +: LANE_W];
            end else begin
                rd_d = mem[rd_addr];
            end
        end

        always_ff @(posedge core_clk) begin
            if (wr_en[g]) begin
                mem[wr_addr] <= wr_data[g*LANE_W +: LANE_W];
            end
        end

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                rd_q <= '0;
            end else begin
                rd_q <= rd_d;
            end
        end

        assign rd_data[g*LANE_W +: LANE_W] = rd_q;
    end

endmodule : dfc_stack_mem

//--- hdl/dfc_flow_ctrl.sv
// Program flow control: call stack, branches, repeat counter and loop stack
// What this block does
// - A call bumps the call stack pointer up before storing anything.
// - The call then stores the current fetch counter at the bumped pointer.
// - Immediate targets add the signed operand to the current fetch counter.
// - Register-indirect targets load the pointer register value unchanged.
// - A subroutine exit reloads the fetch counter, then drops the pointer.
// - Calls time like jumps; returns take two instruction cycles.
// - Interrupt acknowledge pushes the fetch address and loads the vector.
// - A 16-bit repeat count register holds the requested repetitions.
// - 16-bit loop start and end registers bound the active loop.
// - Loop count loads at entry, decrements per pass, ends the loop.
// - Four-level loop stack saves start, end, count; restores on exit.
// - The loop stack is reached as three 16-bit bus transfer registers.
// - Reading stacked start drops the pointer after; writing bumps it before.
// - Loop save pointer is bus readable, writable, ranges 0..4, resets to 0.
// - Loop save pointer counts in bits 2..0; upper bits read zero.
// - Loop save pointer rises on loop save, falls on restore or discard.
// - A loop save pointer outside 0..4 is a stack error.
// - Loop start, end, count, loop stack and loop save pointer reach the main bus; fetch counter, call stack pointer and repeat count do not.
// - Stack overflow or underflow sets the sticky stack error flag.
// - A taken conditional immediate branch, immediate call or return costs one more cycle; untaken costs one.
// - Immediate offsets are 16-bit two's complement over the whole space.
`timescale 1ns/1ps
`include "dfc_regs.svh"
module dfc_flow_ctrl #(
    parameter int AW         = 16,
    parameter int CS_PTR_W   = 4,
    parameter int LOOP_PTR_W = 3
) (
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    input  wire logic            op_valid,
    input  wire dfc_pkg::dfc_op_e op_kind,
    input  wire logic            op_cond,
    input  wire logic            cond_true,
    input  wire logic [AW-1:0]   imm_offset,
    input  wire logic [AW-1:0]   pointer_reg_n,
    input  wire logic [AW-1:0]   int_target,
    input  wire logic [15:0]     loop_start_in,
    input  wire logic [15:0]     loop_end_in,
    input  wire logic [15:0]     loop_count_in,
    input  wire logic [15:0]     repeat_count_in,
    input  wire logic            bus_rd,
    input  wire logic            bus_wr,
    input  wire dfc_pkg::dfc_sel_t bus_sel,
    input  wire logic [15:0]     bus_wdata,
    input  wire logic            err_clr,
    output logic                 op_ready,
    output logic [AW-1:0]        fetch_counter,
    output logic [CS_PTR_W-1:0]  call_stack_ptr,
    output logic [15:0]          loop_save_ptr,
    output logic [15:0]          bus_rdata,
    output logic                 stack_err,
    output logic                 loop_done,
    output logic                 repeat_active
);
    import dfc_pkg::*;

    // -------------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------------
    logic [AW-1:0]          pc_q;
    logic [AW-1:0]          pc_d;
    logic [CS_PTR_W-1:0]    sp_q;
    logic [CS_PTR_W-1:0]    sp_d;
    logic [LOOP_PTR_W-1:0]  lsp_q;
    logic [LOOP_PTR_W-1:0]  lsp_d;
    logic [15:0]            loop_start_addr_q;
    logic [15:0]            loop_start_addr_d;
    logic [15:0]            loop_end_addr_q;
    logic [15:0]            loop_end_addr_d;
    logic [15:0]            loop_count_reg_q;
    logic [15:0]            loop_count_reg_d;
    logic [15:0]            repeat_count_reg_q;
    logic [15:0]            repeat_count_reg_d;
    logic                   rep_q;
    logic                   rep_d;
    logic [1:0]             stall_q;
    logic [1:0]             stall_d;
    logic                   ready_q;
    logic                   err_q;
    logic                   err_d;
    logic                   done_q;
    logic                   done_d;
    logic [15:0]            rdata_q;
    logic [15:0]            rdata_d;

    // -------------------------------------------------------------------------
    // Memory ports
    // -------------------------------------------------------------------------
    logic                   cs_we;
    logic [CS_PTR_W-1:0]    cs_waddr;
    logic [AW-1:0]          cs_rdata;
    logic [2:0]             lf_we;
    logic [LOOP_PTR_W-1:0]  lf_waddr;
    logic [47:0]            lf_wdata;
    logic [47:0]            lf_rdata;

    // -------------------------------------------------------------------------
    // Decode helpers
    // -------------------------------------------------------------------------
    logic                   take;
    logic [1:0]             extra;
    logic                   advance;
    logic [LOOP_PTR_W-1:0]  lsp_max;

    assign lsp_max = LOOP_PTR_W'(`DFC_LOOP_PTR_MAX);

    // -------------------------------------------------------------------------
    // Call return store: entry at the pointer is always on cs_rdata
    // -------------------------------------------------------------------------
    dfc_stack_mem #(
        .LANES  (1),
        .LANE_W (AW),
        .ADDR_W (CS_PTR_W)
    ) u_call_return_store (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (cs_we),
        .wr_addr  (cs_waddr),
        .wr_data  (pc_q),
        .rd_addr  (sp_d),
        .rd_data  (cs_rdata)
    );

    // -------------------------------------------------------------------------
    // Loop save file: start, end, count lanes per level
    // -------------------------------------------------------------------------
    dfc_stack_mem #(
        .LANES  (3),
        .LANE_W (16),
        .ADDR_W (LOOP_PTR_W)
    ) u_loop_save_file (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (lf_we),
        .wr_addr  (lf_waddr),
        .wr_data  (lf_wdata),
        .rd_addr  (lsp_d),
        .rd_data  (lf_rdata)
    );

    // -------------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------------
    always_comb begin
        pc_d               = pc_q;
        sp_d               = sp_q;
        lsp_d              = lsp_q;
        loop_start_addr_d  = loop_start_addr_q;
        loop_end_addr_d    = loop_end_addr_q;
        loop_count_reg_d   = loop_count_reg_q;
        repeat_count_reg_d = repeat_count_reg_q;
        rep_d              = rep_q;
        stall_d            = (stall_q != 2'h0) ? stall_q - 2'h1 : 2'h0;
        err_d              = err_q & ~err_clr;
        done_d             = 1'b0;
        rdata_d            = rdata_q;
        cs_we              = 1'b0;
        cs_waddr           = sp_q + CS_PTR_W'(1);
        lf_we              = 3'h0;
        lf_waddr           = lsp_q + LOOP_PTR_W'(1);
        lf_wdata           = {loop_start_addr_q, loop_end_addr_q, loop_count_reg_q};
        take               = ~op_cond | cond_true;
        extra              = op_cond ? `DFC_CYC_COND_EXTRA : 2'h0;
        advance            = 1'b0;

        if (stall_q != 2'h0) begin
            pc_d = pc_q;
        end else if (rep_q) begin
            // Fetch counter holds while the single instruction repeats
            repeat_count_reg_d = repeat_count_reg_q - 16'h1;
            if (repeat_count_reg_q <= 16'h1) begin
                rep_d = 1'b0;
                pc_d  = pc_q + AW'(1);
            end
        end else if (op_valid && !take) begin
            advance = 1'b1;
        end else if (op_valid) begin
            unique case (op_kind)
                DFC_OP_BRANCH_IMM: begin
                    pc_d    = pc_q + imm_offset;
                    stall_d = `DFC_CYC_IMM - 2'h1 + extra;
                end
                DFC_OP_BRANCH_IND: begin
                    pc_d    = pointer_reg_n;
                    stall_d = `DFC_CYC_IND - 2'h1;
                end
                DFC_OP_CALL_IMM, DFC_OP_CALL_IND: begin
                    sp_d  = sp_q + CS_PTR_W'(1);
                    cs_we = 1'b1;
                    if (sp_q == '1) begin
                        err_d = 1'b1;
                    end
                    if (op_kind == DFC_OP_CALL_IMM) begin
                        pc_d    = pc_q + imm_offset;
                        stall_d = `DFC_CYC_IMM - 2'h1 + extra;
                    end else begin
                        pc_d    = pointer_reg_n;
                        stall_d = `DFC_CYC_IND - 2'h1;
                    end
                end
                DFC_OP_SUB_EXIT, DFC_OP_INT_EXIT: begin
                    pc_d    = cs_rdata;
                    sp_d    = sp_q - CS_PTR_W'(1);
                    stall_d = `DFC_CYC_IMM - 2'h1 + extra;
                    if (sp_q == '0) begin
                        err_d = 1'b1;
                    end
                end
                DFC_OP_INT_ACK: begin
                    sp_d    = sp_q + CS_PTR_W'(1);
                    cs_we   = 1'b1;
                    pc_d    = int_target;
                    stall_d = `DFC_CYC_IMM - 2'h1;
                    if (sp_q == '1) begin
                        err_d = 1'b1;
                    end
                end
                DFC_OP_LOOP_ENTER: begin
                    lsp_d             = lsp_q + LOOP_PTR_W'(1);
                    lf_we             = 3'h7;
                    loop_start_addr_d = loop_start_in;
                    loop_end_addr_d   = loop_end_in;
                    loop_count_reg_d  = loop_count_in;
                    pc_d              = pc_q + AW'(1);
                end
                DFC_OP_LOOP_DISCARD: begin
                    {loop_start_addr_d, loop_end_addr_d, loop_count_reg_d} = lf_rdata;
                    lsp_d = lsp_q - LOOP_PTR_W'(1);
                    pc_d  = pc_q + AW'(1);
                end
                DFC_OP_SINGLE_ITERATE: begin
                    repeat_count_reg_d = repeat_count_in;
                    rep_d              = (repeat_count_in != 16'h0);
                    pc_d               = pc_q + AW'(1);
                    stall_d            = `DFC_CYC_REP_GAP;
                end
                default: begin
                    advance = 1'b1;
                end
            endcase
        end else begin
            advance = 1'b1;
        end

        // ---------------------------------------------------------------------
        // Plain fetch, with loop end detection at the end address
        // ---------------------------------------------------------------------
        if (advance) begin
            pc_d = pc_q + AW'(1);
            if ((lsp_q != '0) && (pc_q[15:0] == loop_end_addr_q)) begin
                if (loop_count_reg_q > 16'h1) begin
                    loop_count_reg_d = loop_count_reg_q - 16'h1;
                    pc_d             = AW'(loop_start_addr_q);
                end else begin
                    loop_count_reg_d = 16'h0;
                    done_d           = 1'b1;
                    {loop_start_addr_d, loop_end_addr_d, loop_count_reg_d} = lf_rdata;
                    lsp_d            = lsp_q - LOOP_PTR_W'(1);
                end
            end
        end

        // ---------------------------------------------------------------------
        // Main bus transfers; repeat count has no select
        // ---------------------------------------------------------------------
        if (bus_rd) begin
            unique case (bus_sel)
                `DFC_SEL_LOOP_START: rdata_d = loop_start_addr_q;
                `DFC_SEL_LOOP_END:   rdata_d = loop_end_addr_q;
                `DFC_SEL_LOOP_COUNT: rdata_d = loop_count_reg_q;
                `DFC_SEL_STK_START: begin
                    rdata_d = lf_rdata[`DFC_LANE_START*16 +: 16];
                    lsp_d   = lsp_q - LOOP_PTR_W'(1);
                end
                `DFC_SEL_STK_END:    rdata_d = lf_rdata[`DFC_LANE_END*16 +: 16];
                `DFC_SEL_STK_COUNT:  rdata_d = lf_rdata[`DFC_LANE_COUNT*16 +: 16];
                `DFC_SEL_LOOP_PTR:   rdata_d = {{(16-LOOP_PTR_W){1'b0}}, lsp_q};
                default:             rdata_d = `DFC_RST_WORD;
            endcase
        end else if (bus_wr) begin
            unique case (bus_sel)
                `DFC_SEL_LOOP_START: loop_start_addr_d = bus_wdata;
                `DFC_SEL_LOOP_END:   loop_end_addr_d   = bus_wdata;
                `DFC_SEL_LOOP_COUNT: loop_count_reg_d  = bus_wdata;
                `DFC_SEL_STK_START: begin
                    lsp_d    = lsp_q + LOOP_PTR_W'(1);
                    lf_waddr = lsp_q + LOOP_PTR_W'(1);
                    lf_we    = 3'h1 << `DFC_LANE_START;
                    lf_wdata = {3{bus_wdata}};
                end
                `DFC_SEL_STK_END: begin
                    lf_waddr = lsp_q;
                    lf_we    = 3'h1 << `DFC_LANE_END;
                    lf_wdata = {3{bus_wdata}};
                end
                `DFC_SEL_STK_COUNT: begin
                    lf_waddr = lsp_q;
                    lf_we    = 3'h1 << `DFC_LANE_COUNT;
                    lf_wdata = {3{bus_wdata}};
                end
                `DFC_SEL_LOOP_PTR:   lsp_d = bus_wdata[LOOP_PTR_W-1:0];
                default:             lsp_d = lsp_d;
            endcase
        end

        // Out-of-range loop pointer: overflow or underflow
        if (lsp_d > lsp_max) begin
            err_d = 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q               <= '0;
            sp_q               <= '0;
            lsp_q              <= LOOP_PTR_W'(`DFC_RST_LOOP_PTR);
            loop_start_addr_q  <= `DFC_RST_WORD;
            loop_end_addr_q    <= `DFC_RST_WORD;
            loop_count_reg_q   <= `DFC_RST_WORD;
            repeat_count_reg_q <= `DFC_RST_WORD;
            rep_q              <= 1'b0;
            stall_q            <= 2'h0;
            ready_q            <= 1'b0;
            err_q              <= 1'b0;
            done_q             <= 1'b0;
            rdata_q            <= `DFC_RST_WORD;
        end else begin
            pc_q               <= pc_d;
            sp_q               <= sp_d;
            lsp_q              <= lsp_d;
            loop_start_addr_q  <= loop_start_addr_d;
            loop_end_addr_q    <= loop_end_addr_d;
            loop_count_reg_q   <= loop_count_reg_d;
            repeat_count_reg_q <= repeat_count_reg_d;
            rep_q              <= rep_d;
            stall_q            <= stall_d;
            ready_q            <= (stall_d == 2'h0) && !rep_d;
            err_q              <= err_d;
            done_q             <= done_d;
            rdata_q            <= rdata_d;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------------
    assign op_ready       = ready_q;
    assign fetch_counter  = pc_q;
    assign call_stack_ptr = sp_q;
    assign loop_save_ptr  = {{(16-LOOP_PTR_W){1'b0}}, lsp_q};
    assign bus_rdata      = rdata_q;
    assign stack_err      = err_q;
    assign loop_done      = done_q;
    assign repeat_active  = rep_q;

endmodule : dfc_flow_ctrl

//--- dv/dfc_flow_ctrl_sva.sv
// Assertion checker for the flow control block
`timescale 1ns/1ps
module dfc_flow_ctrl_sva import dfc_pkg::*; #(
    parameter int AW       = 16,
    parameter int CS_PTR_W = 4
) (
    input wire logic                core_clk,
    input wire logic                rst_n,
    input wire logic                op_valid,
    input wire dfc_op_e             op_kind,
    input wire logic                op_cond,
    input wire logic                cond_true,
    input wire logic [AW-1:0]       imm_offset,
    input wire logic [AW-1:0]       pointer_reg_n,
    input wire logic                op_ready,
    input wire logic [AW-1:0]       fetch_counter,
    input wire logic [CS_PTR_W-1:0] call_stack_ptr,
    input wire logic [15:0]         loop_save_ptr,
    input wire logic                stack_err
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Op accepted and its branch taken
    wire logic tk = op_valid && op_ready && (!op_cond || cond_true);
    a_upper_zero: assert property (loop_save_ptr[15:3] == 13'h0000)
        else $error("loop pointer upper bits set");
    a_call_push: assert property (tk && op_kind == DFC_OP_CALL_IMM && call_stack_ptr != '1
        |=> call_stack_ptr == $past(call_stack_ptr) + 1'b1) else $error("call did not push");
    a_imm_target: assert property (tk && op_kind == DFC_OP_BRANCH_IMM
        |=> fetch_counter == $past(fetch_counter) + $past(imm_offset)) else $error("bad imm target");
    a_ind_target: assert property (tk && op_kind inside {DFC_OP_BRANCH_IND, DFC_OP_CALL_IND}
        |=> fetch_counter == $past(pointer_reg_n)) else $error("bad indirect target");
    a_exit_pop: assert property (tk && op_kind == DFC_OP_SUB_EXIT && call_stack_ptr != '0
        |=> call_stack_ptr == $past(call_stack_ptr) - 1'b1) else $error("exit did not pop");
    a_exit_cycles: assert property (tk && !op_cond && op_kind == DFC_OP_SUB_EXIT
        |=> !op_ready ##1 op_ready) else $error("return not two cycles");
    a_cond_extra: assert property (tk && op_cond && op_kind == DFC_OP_BRANCH_IMM
        |=> !op_ready [*2] ##1 op_ready) else $error("taken cond branch cycles");
    a_untaken_pass: assert property (op_valid && op_ready && op_cond && !cond_true
        && op_kind == DFC_OP_BRANCH_IMM && loop_save_ptr == '0
        |=> op_ready && fetch_counter == $past(fetch_counter) + 1'b1)
        else $error("untaken branch stalled");
    a_ptr_err: assert property (loop_save_ptr > 16'h0004 |-> ##[0:1] stack_err)
        else $error("pointer error not flagged");
endmodule : dfc_flow_ctrl_sva

bind dfc_flow_ctrl dfc_flow_ctrl_sva #(.AW(AW), .CS_PTR_W(CS_PTR_W)) u_sva (.*);

//--- dv/testbench.sv
// Self-checking testbench for the flow control block
`timescale 1ns/1ps
`include "dfc_regs.svh"
module testbench;
    import dfc_pkg::*;
    logic        core_clk, rst_n, op_valid, op_cond, cond_true, bus_rd, bus_wr, err_clr;
    dfc_op_e     op_kind;
    dfc_sel_t    bus_sel;
    logic [15:0] imm_offset, pointer_reg_n, int_target, loop_start_in, loop_end_in;
    logic [15:0] loop_count_in, repeat_count_in, bus_wdata, pc0, ra, rb;
    logic        op_ready, stack_err, loop_done, repeat_active;
    logic [15:0] fetch_counter, loop_save_ptr, bus_rdata;
    logic [3:0]  call_stack_ptr;
    int          bad_count, check_count, n;

    dfc_flow_ctrl u_dut (.core_clk, .rst_n, .op_valid, .op_kind, .op_cond, .cond_true,
        .imm_offset, .pointer_reg_n, .int_target, .loop_start_in, .loop_end_in, .loop_count_in,
        .repeat_count_in, .bus_rd, .bus_wr, .bus_sel, .bus_wdata, .err_clr, .op_ready,
        .fetch_counter, .call_stack_ptr, .loop_save_ptr, .bus_rdata, .stack_err, .loop_done,
        .repeat_active);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic op(input dfc_op_e k, input logic c, input logic t);
        @(negedge core_clk);
        for (n = 0; n < 20 && op_ready !== 1'b1; n++) @(negedge core_clk);
        if (n == 20) begin
            chk(op_ready, 16'h0001);
            end_sim();
        end
        pc0 = fetch_counter;
        op_kind = k;
        op_cond = c;
        cond_true = t;
        op_valid = 1'b1;
        @(negedge core_clk);
        op_valid = 1'b0;
    endtask : op

    task automatic wr(input dfc_sel_t s, input logic [15:0] d);
        bus_sel = s;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge core_clk);
        bus_wr = 1'b0;
        @(negedge core_clk);
    endtask : wr

    task automatic rd(input dfc_sel_t s, input logic [15:0] e);
        bus_sel = s;
        bus_rd = 1'b1;
        @(negedge core_clk);
        bus_rd = 1'b0;
        chk(bus_rdata, e);
        @(negedge core_clk);
    endtask : rd

    task automatic t_flow();
        imm_offset = 16'hFFF0;
        op(DFC_OP_CALL_IMM, 1'b0, 1'b0);
        ra = pc0;
        chk(fetch_counter, pc0 + 16'hFFF0);
        chk(call_stack_ptr, 16'h0001);
        op(DFC_OP_SUB_EXIT, 1'b0, 1'b0);
        chk(fetch_counter, ra);
        chk(call_stack_ptr, 16'h0000);
        imm_offset = 16'h0010;
        op(DFC_OP_BRANCH_IMM, 1'b1, 1'b1);
        chk(fetch_counter, pc0 + 16'h0010);
        op(DFC_OP_BRANCH_IMM, 1'b1, 1'b0);
        chk(fetch_counter, pc0 + 16'h0001);
        pointer_reg_n = 16'h1234;
        op(DFC_OP_CALL_IND, 1'b0, 1'b0);
        ra = pc0;
        chk(fetch_counter, 16'h1234);
        int_target = 16'h0200;
        op(DFC_OP_INT_ACK, 1'b0, 1'b0);
        rb = pc0;
        chk(fetch_counter, 16'h0200);
        chk(call_stack_ptr, 16'h0002);
        op(DFC_OP_INT_EXIT, 1'b0, 1'b0);
        chk(fetch_counter, rb);
        op(DFC_OP_SUB_EXIT, 1'b0, 1'b0);
        chk(fetch_counter, ra);
        $display("flow test done");
    endtask : t_flow

    task automatic t_bus();
        wr(`DFC_SEL_LOOP_START, 16'h1111);
        wr(`DFC_SEL_LOOP_END, 16'hC000);
        wr(`DFC_SEL_LOOP_COUNT, 16'h0003);
        rd(`DFC_SEL_LOOP_START, 16'h1111);
        rd(`DFC_SEL_LOOP_END, 16'hC000);
        rd(`DFC_SEL_LOOP_COUNT, 16'h0003);
        wr(`DFC_SEL_STK_START, 16'h2222);
        chk(loop_save_ptr, 16'h0001);
        wr(`DFC_SEL_STK_COUNT, 16'h0033);
        rd(`DFC_SEL_STK_COUNT, 16'h0033);
        rd(`DFC_SEL_STK_START, 16'h2222);
        chk(loop_save_ptr, 16'h0000);
        rd(3'h7, 16'h0000);
        $display("bus test done");
    endtask : t_bus

    task automatic t_loop();
        loop_start_in = fetch_counter + 16'h0003;
        loop_end_in = fetch_counter + 16'h0005;
        loop_count_in = 16'h0002;
        op(DFC_OP_LOOP_ENTER, 1'b0, 1'b0);
        chk(loop_save_ptr, 16'h0001);
        for (n = 0; n < 40 && loop_done !== 1'b1; n++) @(negedge core_clk);
        chk(loop_done, 16'h0001);
        if (n == 40) end_sim();
        chk(loop_save_ptr, 16'h0000);
        rd(`DFC_SEL_LOOP_END, 16'hC000);
        loop_end_in = 16'hF000;
        op(DFC_OP_LOOP_ENTER, 1'b0, 1'b0);
        op(DFC_OP_LOOP_DISCARD, 1'b0, 1'b0);
        chk(loop_save_ptr, 16'h0000);
        rd(`DFC_SEL_LOOP_COUNT, 16'h0003);
        repeat_count_in = 16'h0003;
        op(DFC_OP_SINGLE_ITERATE, 1'b0, 1'b0);
        ra = fetch_counter;
        for (n = 0; n < 5 && repeat_active !== 1'b1; n++) @(negedge core_clk);
        for (n = 0; n < 20 && repeat_active === 1'b1; n++) @(negedge core_clk);
        chk(16'(n), 16'h0003 + `DFC_CYC_REP_GAP);
        chk(fetch_counter, ra + 16'h0001);
        $display("loop test done");
    endtask : t_loop

    task automatic t_err();
        wr(`DFC_SEL_LOOP_PTR, 16'h0004);
        rd(`DFC_SEL_LOOP_PTR, 16'h0004);
        wr(`DFC_SEL_STK_START, 16'h4444);
        chk(stack_err, 16'h0001);
        wr(`DFC_SEL_LOOP_PTR, 16'h0000);
        err_clr = 1'b1;
        @(negedge core_clk);
        err_clr = 1'b0;
        chk(stack_err, 16'h0000);
        $display("error test done");
    endtask : t_err

    initial begin
        {rst_n, op_valid, op_cond, cond_true, bus_rd, bus_wr, err_clr} = 7'h00;
        {imm_offset, pointer_reg_n, int_target, bus_wdata} = 64'h0;
        {loop_start_in, loop_end_in, loop_count_in, repeat_count_in} = 64'h0;
        op_kind = DFC_OP_BRANCH_IMM;
        bus_sel = 3'h0;
        bad_count = 0;
        check_count = 0;
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        chk(loop_save_ptr, 16'h0000);
        chk(call_stack_ptr, 16'h0000);
        repeat (2) @(negedge core_clk);
        t_flow();
        t_bus();
        t_loop();
        t_err();
        end_sim();
    end
endmodule : testbench
